// *** hdl/serial_dma_pkg.sv ***
// Constants, field layout and types shared by the serial DMA control logic.
// Assumes one synchronous clock domain and a simple selected register port.
package serial_dma_pkg;

	// -----------------------------------------------------------------
	// Register selection
	// -----------------------------------------------------------------
	localparam logic [1:0] REG_CONFIG = 2'h0;
	localparam logic [1:0] REG_FLAGS = 2'h1;
	localparam logic [1:0] REG_FAULT = 2'h2;

	// -----------------------------------------------------------------
	// Configuration register layout
	// -----------------------------------------------------------------
	localparam int CFG_WIDTH = 16;
	localparam logic [15:0] CFG_RESET = 16'h0000;
	localparam logic [15:0] CFG_WRITABLE = 16'h677b;
	localparam int HALT_SEL_LSB = 13;
	localparam int SERVICE_MASK_LSB = 8;
	localparam int ARB_ID_LSB = 4;
	localparam int TEST_IE_BIT = 3;
	localparam int ERROR_IE_BIT = 1;
	localparam int BKPT_IE_BIT = 0;

	localparam logic [1:0] HALT_IGNORE = 2'h0;
	localparam logic [1:0] HALT_FREEZE = 2'h2;

	// -----------------------------------------------------------------
	// Event register layout
	// -----------------------------------------------------------------
	localparam int FLAG_WIDTH = 8;
	localparam logic [7:0] FLAG_RESET = 8'h00;
	localparam logic [7:0] FLAG_IMPLEMENTED = 8'h07;
	localparam int BKPT_FLAG_BIT = 0;
	localparam int BERR_FLAG_BIT = 1;
	localparam int TEST_FLAG_BIT = 2;

	localparam int ADDR_WIDTH = 32;
	localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

	// -----------------------------------------------------------------
	// Bus ownership states
	// -----------------------------------------------------------------
	typedef enum logic [1:0] {
		OWN_IDLE = 2'b00,
		OWN_REQUEST = 2'b01,
		OWN_TRANSFER = 2'b10,
		OWN_STOPPED = 2'b11
	} own_state_t;

endpackage : serial_dma_pkg

// *** hdl/dma_event_flags_reg.sv ***
// Write-one-to-clear event register for the serial DMA channels.
// Assumes set strobes and write strobe are synchronous single-cycle pulses.
`timescale 1ns/1ns
module dma_event_flags_reg
	import serial_dma_pkg::*;
(
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic [7:0] setEvents,
	input wire logic clearWrite,
	input wire logic [7:0] clearData,
	output logic [7:0] flags
);

	// -----------------------------------------------------------------
	// Flag storage, set wins over clear
	// -----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			flags <= FLAG_RESET;
		end else if (clearWrite) begin
			flags <= ((flags & ~clearData) | setEvents) & FLAG_IMPLEMENTED;
		end else begin
			flags <= (flags | setEvents) & FLAG_IMPLEMENTED;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	a_set_beats_clear: assert property (setEvents[BERR_FLAG_BIT] |=> flags[BERR_FLAG_BIT])
		else $error("event lost when set and clear coincide");
	a_reserved_flags: assert property (flags[7:3] == 5'h00)
		else $error("reserved event bits not zero");

endmodule : dma_event_flags_reg

// *** hdl/dma_request_gate.sv ***
// Decides whether the serial DMA channels may hold a bus request this cycle.
// Assumes the service level and halt input are synchronous to mclk.
`timescale 1ns/1ns
module dma_request_gate
	import serial_dma_pkg::*;
(
	input wire logic [1:0] haltSelect,
	input wire logic debugHalt,
	input wire logic [2:0] serviceLevel,
	input wire logic [2:0] serviceMask,
	output logic frozen,
	output logic preempted
);

	// -----------------------------------------------------------------
	// Hold-off terms
	// -----------------------------------------------------------------
	always_comb begin
		frozen = (haltSelect == HALT_FREEZE) && debugHalt;
		preempted = serviceLevel > serviceMask;
	end

endmodule : dma_request_gate

// *** hdl/serial_dma_control.sv ***
// Shared control and status logic of the fourteen serial DMA channels.
// Assumes a synchronous register port and an internal bus with grant and end-of-cycle strobes.
//
// Overview of operation
// - 16-bit configuration shared by all channels, supervisor access only, zero at reset.
// - Configuration bits 15, 12, 11, 7 and 2 are reserved.
// - Halt select 00 ignores debug halt, 10 freezes on next bus cycle.
// - While frozen the bus request stays low until halt drops or reset.
// - Service level above mask releases bus and drops request until level falls.
// - Arbitration priority field, zero lowest, seven highest.
// - Error interrupt enable plus source mask raise interrupt on bus error.
// - Breakpoint interrupt enable gates interrupt; the flag sets regardless.
// - Higher-level interrupt stops activity at once, else after current transfer.
// - 8-bit event register sets flags regardless of enables; bits 7-3 reserved.
// - Event register readable in supervisor mode only, write one clears, reset clears all.
// - Bus error flag sets on failed channel cycle; fault address readable.
// - Breakpoint flag sets on breakpoint during a transfer; cleared by one.
// - Factory test flag clears on written one, ignores written zero.
// - 32-bit read-only fault address, zero after reset.
// - After a bus error all processor activity stops until processor reset.
// - A channel holds the bus for one long-word transfer, then releases.
`timescale 1ns/1ns
module serial_dma_control
	import serial_dma_pkg::*;
(
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic regSupervisor,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [1:0] regSelect,
	input wire logic [15:0] regWriteData,
	output logic [31:0] regReadData,
	input wire logic channelNeedsBus,
	input wire logic busGrant,
	input wire logic cycleDone,
	input wire logic longWordDone,
	input wire logic busError,
	input wire logic [31:0] accessAddress,
	input wire logic breakpoint,
	input wire logic testEvent,
	input wire logic debugHalt,
	input wire logic [2:0] serviceLevel,
	input wire logic sourceMaskBit,
	input wire logic processorReset,
	output logic busRequest,
	output logic busOwner,
	output logic [2:0] arbitrationId,
	output logic interruptRequest,
	output logic activityStopped
);

	// -----------------------------------------------------------------
	// Helpers
	// -----------------------------------------------------------------
	function automatic logic [2:0] field3(input logic [15:0] cfg, input int lsb);
		field3 = cfg[lsb +: 3];
	endfunction : field3

	function automatic logic accessOk(input logic strobe, input logic supervisor);
		accessOk = strobe && supervisor;
	endfunction : accessOk

	logic [15:0] channelConfig;
	logic [31:0] faultAddress;
	logic [7:0] flags;
	logic [7:0] setEvents;
	own_state_t state;
	own_state_t next_state;
	logic frozen;
	logic preempted;
	logic ownedError;
	logic ownedBreak;
	logic cfgWrite;
	logic flagWrite;
	logic next_busRequest;
	logic next_busOwner;
	logic next_interrupt;
	logic [31:0] next_readData;

	assign cfgWrite = accessOk(regWrite, regSupervisor) && (regSelect == REG_CONFIG);
	assign flagWrite = accessOk(regWrite, regSupervisor) && (regSelect == REG_FLAGS);
	assign ownedError = busOwner && busError;
	assign ownedBreak = busOwner && breakpoint;

	// -----------------------------------------------------------------
	// Configuration register
	// -----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			channelConfig <= CFG_RESET;
		end else if (cfgWrite) begin
			channelConfig <= regWriteData & CFG_WRITABLE;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			arbitrationId <= 3'h0;
		end else begin
			arbitrationId <= field3(channelConfig, ARB_ID_LSB);
		end
	end

	// -----------------------------------------------------------------
	// Request gating and events
	// -----------------------------------------------------------------
	dma_request_gate dma_request_gate_inst (
		.haltSelect(channelConfig[HALT_SEL_LSB +: 2]),
		.debugHalt(debugHalt),
		.serviceLevel(serviceLevel),
		.serviceMask(field3(channelConfig, SERVICE_MASK_LSB)),
		.frozen(frozen),
		.preempted(preempted)
	);

	always_comb begin
		setEvents = 8'h00;
		setEvents[BERR_FLAG_BIT] = ownedError;
		setEvents[BKPT_FLAG_BIT] = ownedBreak;
		setEvents[TEST_FLAG_BIT] = testEvent;
	end

	dma_event_flags_reg dma_event_flags_reg_inst (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.setEvents(setEvents),
		.clearWrite(flagWrite),
		.clearData(regWriteData[7:0]),
		.flags(flags)
	);

	// -----------------------------------------------------------------
	// Fault address capture
	// -----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			faultAddress <= DATA_ZERO;
		end else if (ownedError) begin
			faultAddress <= accessAddress;
		end
	end

	// -----------------------------------------------------------------
	// Processor stop after bus error
	// -----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			activityStopped <= 1'b0;
		end else if (ownedError) begin
			activityStopped <= 1'b1;
		end else if (processorReset) begin
			activityStopped <= 1'b0;
		end
	end

	// -----------------------------------------------------------------
	// Bus ownership sequence
	// -----------------------------------------------------------------
	always_comb begin
		next_state = state;
		unique case (state)
			OWN_IDLE: begin
				if (channelNeedsBus && !activityStopped) begin
					next_state = OWN_REQUEST;
				end
			end
			OWN_REQUEST: begin
				if (activityStopped) begin
					next_state = OWN_STOPPED;
				end else if (busGrant && busRequest && !frozen && !preempted) begin
					next_state = OWN_TRANSFER;
				end
			end
			OWN_TRANSFER: begin
				if (busError) begin
					next_state = OWN_STOPPED;
				end else if (longWordDone) begin
					next_state = OWN_IDLE;
				end else if (preempted) begin
					next_state = OWN_REQUEST;
				end else if (frozen && cycleDone) begin
					next_state = OWN_REQUEST;
				end
			end
			OWN_STOPPED: begin
				if (processorReset && !activityStopped) begin
					next_state = OWN_IDLE;
				end else if (!activityStopped) begin
					next_state = OWN_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			state <= OWN_IDLE;
		end else begin
			state <= next_state;
		end
	end

	always_comb begin
		next_busOwner = next_state == OWN_TRANSFER;
		next_busRequest = (next_state == OWN_REQUEST) && !frozen && !preempted
			&& !activityStopped && !ownedError;
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			busRequest <= 1'b0;
			busOwner <= 1'b0;
		end else begin
			busRequest <= next_busRequest;
			busOwner <= next_busOwner;
		end
	end

	// -----------------------------------------------------------------
	// Interrupt request
	// -----------------------------------------------------------------
	always_comb begin
		next_interrupt = sourceMaskBit && (
			(flags[BERR_FLAG_BIT] && channelConfig[ERROR_IE_BIT]) ||
			(flags[BKPT_FLAG_BIT] && channelConfig[BKPT_IE_BIT]) ||
			(flags[TEST_FLAG_BIT] && channelConfig[TEST_IE_BIT]));
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			interruptRequest <= 1'b0;
		end else begin
			interruptRequest <= next_interrupt;
		end
	end

	// -----------------------------------------------------------------
	// Register read port
	// -----------------------------------------------------------------
	always_comb begin
		next_readData = DATA_ZERO;
		if (accessOk(regRead, regSupervisor)) begin
			unique case (regSelect)
				REG_CONFIG: next_readData = {16'h0000, channelConfig};
				REG_FLAGS: next_readData = {24'h000000, flags};
				REG_FAULT: next_readData = faultAddress;
				default: next_readData = DATA_ZERO;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			regReadData <= DATA_ZERO;
		end else begin
			regReadData <= next_readData;
		end
	end

	// -----------------------------------------------------------------
	// Checks
	// -----------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	sequence seq_owned_error;
		busOwner && busError;
	endsequence

	sequence seq_clear_berr;
		flagWrite && regWriteData[BERR_FLAG_BIT] && !ownedError;
	endsequence

	a_config_reserved: assert property (channelConfig[15] == 1'b0 && channelConfig[12:11] == 2'h0
		&& channelConfig[7] == 1'b0 && channelConfig[2] == 1'b0)
		else $error("reserved configuration bit set");
	a_config_write: assert property (cfgWrite |=> channelConfig == ($past(regWriteData) & CFG_WRITABLE))
		else $error("configuration write not stored");
	a_freeze_drop: assert property (frozen |=> !busRequest)
		else $error("bus request while frozen");
	a_ignore_halt: assert property ((channelConfig[HALT_SEL_LSB +: 2] == HALT_IGNORE) |-> !frozen)
		else $error("halt not ignored with code zero");
	a_mask_yield: assert property (preempted |=> !busRequest)
		else $error("request held above service mask");
	a_preempt_release: assert property (busOwner && preempted && !busError && !longWordDone
		|=> !busOwner)
		else $error("bus kept above service mask");
	a_berr_flag: assert property (seq_owned_error |=> flags[BERR_FLAG_BIT])
		else $error("bus error flag not set");
	a_fault_capture: assert property (seq_owned_error |=> faultAddress == $past(accessAddress))
		else $error("fault address not captured");
	a_fault_hold: assert property (!ownedError |=> $stable(faultAddress))
		else $error("fault address changed without error");
	a_stop_after_error: assert property (seq_owned_error |=> activityStopped && !busRequest)
		else $error("activity not stopped after bus error");
	a_stopped_quiet: assert property (activityStopped |-> !next_busRequest)
		else $error("request while stopped");
	a_single_transfer: assert property (busOwner && longWordDone && !busError |=> !busOwner)
		else $error("bus held past one long word");
	a_w1c_clear: assert property (seq_clear_berr |=> !flags[BERR_FLAG_BIT])
		else $error("written one did not clear flag");
	a_bkpt_flag: assert property (ownedBreak |=> flags[BKPT_FLAG_BIT])
		else $error("breakpoint flag not set");
	a_irq_gate: assert property (!sourceMaskBit |=> !interruptRequest)
		else $error("interrupt passed with source masked");
	a_bkpt_irq: assert property (sourceMaskBit && flags[BKPT_FLAG_BIT] && channelConfig[BKPT_IE_BIT]
		|=> interruptRequest)
		else $error("breakpoint interrupt missing");
	a_arb_id: assert property (##1 arbitrationId == $past(channelConfig[ARB_ID_LSB +: 3]))
		else $error("arbitration priority not presented");

endmodule : serial_dma_control

// *** bench/bus_partner_model.sv ***
// Internal bus arbiter and 16-bit slave memory model facing the serial DMA block.
// Assumes one clock; grant delay and error injection come from the bench.
`timescale 1ns/1ns
module bus_partner_model
	import serial_dma_pkg::*;
(
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic busRequest,
	input wire logic busOwner,
	input wire logic [2:0] grantDelay,
	input wire logic injectError,
	input wire logic [31:0] faultAddr,
	output logic busGrant,
	output logic cycleDone,
	output logic longWordDone,
	output logic busError,
	output logic [31:0] accessAddress
);
	logic [2:0] waitCnt;
	logic [2:0] beat;

	// ---------------------------------------------
	// Arbitration
	// ---------------------------------------------
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			waitCnt <= 3'h0;
			busGrant <= 1'b0;
		end else begin
			waitCnt <= busRequest ? waitCnt + 3'h1 : 3'h0;
			busGrant <= busRequest && (waitCnt >= grantDelay);
		end
	end

	// ---------------------------------------------
	// Two bus cycles per long word
	// ---------------------------------------------
	always_ff @(posedge mclk) begin
		if (sys_rst || !busOwner) begin
			beat <= 3'h0;
			cycleDone <= 1'b0;
			longWordDone <= 1'b0;
			busError <= 1'b0;
		end else begin
			beat <= beat + 3'h1;
			cycleDone <= (beat == 3'h1 && !injectError) || beat == 3'h3;
			longWordDone <= beat == 3'h3;
			busError <= beat == 3'h1 && injectError;
		end
	end

	// Address line shows garbage outside ownership
	assign accessAddress = busOwner ? faultAddr : ~faultAddr;
endmodule : bus_partner_model

// *** bench/tb_serial_dma_control.sv ***
// Self-checking bench for the serial DMA control and status block.
// Assumes the package, design files and bus partner model are compiled first.
`timescale 1ns/1ns
module tb_serial_dma_control
	import serial_dma_pkg::*;
;
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	logic regSupervisor = 1'b1;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic [1:0] regSelect = 2'h0;
	logic [15:0] regWriteData = 16'h0000;
	logic channelNeedsBus = 1'b0;
	logic breakpoint = 1'b0;
	logic testEvent = 1'b0;
	logic debugHalt = 1'b0;
	logic [2:0] serviceLevel = 3'h0;
	logic sourceMaskBit = 1'b0;
	logic processorReset = 1'b0;
	logic injectError = 1'b0;
	logic [2:0] grantDelay = 3'h0;
	logic [31:0] faultAddr = 32'h00a5_1234;
	logic [31:0] regReadData;
	logic [31:0] accessAddress;
	logic [2:0] arbitrationId;
	logic busGrant, cycleDone, longWordDone, busError;
	logic busRequest, busOwner, interruptRequest, activityStopped;
	logic [1:0] codes [3] = '{2'h0, 2'h1, 2'h3};
	int miscompares = 0;
	int n_checks = 0;

	always #4 mclk = ~mclk;

	serial_dma_control serial_dma_control_inst (.mclk(mclk), .sys_rst(sys_rst),
		.regSupervisor(regSupervisor), .regWrite(regWrite), .regRead(regRead),
		.regSelect(regSelect), .regWriteData(regWriteData), .regReadData(regReadData),
		.channelNeedsBus(channelNeedsBus), .busGrant(busGrant), .cycleDone(cycleDone),
		.longWordDone(longWordDone), .busError(busError), .accessAddress(accessAddress),
		.breakpoint(breakpoint), .testEvent(testEvent), .debugHalt(debugHalt),
		.serviceLevel(serviceLevel), .sourceMaskBit(sourceMaskBit),
		.processorReset(processorReset), .busRequest(busRequest), .busOwner(busOwner),
		.arbitrationId(arbitrationId), .interruptRequest(interruptRequest),
		.activityStopped(activityStopped));

	bus_partner_model bus_partner_model_inst (.mclk(mclk), .sys_rst(sys_rst),
		.busRequest(busRequest), .busOwner(busOwner), .grantDelay(grantDelay),
		.injectError(injectError), .faultAddr(faultAddr), .busGrant(busGrant),
		.cycleDone(cycleDone), .longWordDone(longWordDone), .busError(busError),
		.accessAddress(accessAddress));

	// ---------------------------------------------
	// Access and compare tasks
	// ---------------------------------------------
	task automatic conclude;
		$display("Checks %0d, mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : conclude

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask : tick

	task automatic wr(input logic [1:0] sel, input logic [15:0] data);
		@(posedge mclk);
		regWrite <= 1'b1;
		regSelect <= sel;
		regWriteData <= data;
		@(posedge mclk);
		regWrite <= 1'b0;
	endtask : wr

	task automatic rd(input logic [1:0] sel, input logic [31:0] exp);
		@(posedge mclk);
		regRead <= 1'b1;
		regSelect <= sel;
		@(posedge mclk);
		regRead <= 1'b0;
		#1;
		chk(regReadData, exp);
	endtask : rd

	// Bounded wait: 0 owner, 1 request, 2 stopped
	task automatic waitSig(input int sel, input logic v);
		logic s;
		for (int i = 0; i < 40; i++) begin
			@(posedge mclk);
			#1;
			s = sel == 0 ? busOwner : (sel == 1 ? busRequest : activityStopped);
			if (s === v)
				return;
		end
		chk({31'h0, s}, {31'h0, v});
		conclude();
	endtask : waitSig

	// ---------------------------------------------
	// Scenarios
	// ---------------------------------------------
	initial begin
		tick(10);
		sys_rst <= 1'b0;
		rd(REG_CONFIG, 32'h0);
		rd(REG_FLAGS, 32'h0);
		wr(REG_CONFIG, 16'hffff);
		rd(REG_CONFIG, 32'h0000_677b);
		chk({29'h0, arbitrationId}, 32'h7);
		@(posedge mclk);
		regSupervisor <= 1'b0;
		wr(REG_CONFIG, 16'h0000);
		rd(REG_CONFIG, 32'h0);
		@(posedge mclk);
		regSupervisor <= 1'b1;
		rd(REG_CONFIG, 32'h0000_677b);
		rd(2'h3, 32'h0);
		wr(REG_CONFIG, 16'h0740);
		tick(2);
		chk({29'h0, arbitrationId}, 32'h4);
		$display("test registers done");

		@(posedge mclk);
		testEvent <= 1'b1;
		@(posedge mclk);
		testEvent <= 1'b0;
		rd(REG_FLAGS, 32'h4);
		wr(REG_FLAGS, 16'h00fb);
		rd(REG_FLAGS, 32'h4);
		wr(REG_FLAGS, 16'h0004);
		rd(REG_FLAGS, 32'h0);
		@(posedge mclk);
		breakpoint <= 1'b1;
		tick(3);
		rd(REG_FLAGS, 32'h0);
		@(posedge mclk);
		channelNeedsBus <= 1'b1;
		waitSig(0, 1'b1);
		chk({31'h0, busRequest}, 32'h0);
		waitSig(0, 1'b0);
		@(posedge mclk);
		channelNeedsBus <= 1'b0;
		breakpoint <= 1'b0;
		rd(REG_FLAGS, 32'h1);
		@(posedge mclk);
		sourceMaskBit <= 1'b1;
		tick(3);
		chk({31'h0, interruptRequest}, 32'h0);
		wr(REG_CONFIG, 16'h0741);
		tick(2);
		chk({31'h0, interruptRequest}, 32'h1);
		@(posedge mclk);
		sourceMaskBit <= 1'b0;
		tick(3);
		chk({31'h0, interruptRequest}, 32'h0);
		@(posedge mclk);
		sourceMaskBit <= 1'b1;
		tick(3);
		wr(REG_FLAGS, 16'h0001);
		tick(2);
		chk({31'h0, interruptRequest}, 32'h0);
		$display("test events done");

		wr(REG_CONFIG, 16'h0441);
		@(posedge mclk);
		serviceLevel <= 3'h5;
		grantDelay <= 3'h3;
		channelNeedsBus <= 1'b1;
		tick(6);
		chk({30'h0, busRequest, busOwner}, 32'h0);
		@(posedge mclk);
		serviceLevel <= 3'h4;
		waitSig(0, 1'b1);
		foreach (codes[k]) begin
			wr(REG_CONFIG, {1'b0, codes[k], 13'h0740});
			@(posedge mclk);
			debugHalt <= 1'b1;
			waitSig(1, 1'b1);
		end
		wr(REG_CONFIG, 16'h4740);
		tick(8);
		chk({30'h0, busRequest, busOwner}, 32'h0);
		@(posedge mclk);
		debugHalt <= 1'b0;
		waitSig(1, 1'b1);
		$display("test arbitration done");

		wr(REG_CONFIG, 16'h0742);
		@(posedge mclk);
		injectError <= 1'b1;
		waitSig(2, 1'b1);
		@(posedge mclk);
		injectError <= 1'b0;
		faultAddr <= 32'h0000_0000;
		rd(REG_FLAGS, 32'h2);
		rd(REG_FAULT, 32'h00a5_1234);
		chk({31'h0, interruptRequest}, 32'h1);
		tick(5);
		chk({30'h0, busRequest, busOwner}, 32'h0);
		wr(REG_FLAGS, 16'h0002);
		rd(REG_FAULT, 32'h00a5_1234);
		@(posedge mclk);
		processorReset <= 1'b1;
		@(posedge mclk);
		processorReset <= 1'b0;
		waitSig(2, 1'b0);
		waitSig(0, 1'b1);
		$display("test bus error done");
		conclude();
	end
endmodule : tb_serial_dma_control
